// file: src/pcr_power_reset.sv
// Functional notes
// [RULE1] baud doubler bit 7 doubles serial port zero rate in modes 1-3
// [RULE2] quiet strobe bit 5 stops address latch strobe; reset clears it
// [RULE3] software sets load permit bit 4 before loading watchdog timer
// [RULE4] hardware clears load permit bit when watchdog timer is loaded
// [RULE5] bits 3 and 2 are plain user flags without hardware effect
// [RULE6] deep sleep bit 1 enters power-down only while permit input is high
// [RULE7] writing light sleep bit 0 enters idle mode
// [RULE8] both sleep bits written together gives power-down, not idle
// [RULE9] register reached only by byte accesses, never single-bit operations
// [RULE10] reset loads zero into every bit; bit 6 reserved
// [RULE11] filtered reset pin sampled once every machine cycle
// [RULE12] external source holds reset pin high at least two machine cycles
// [RULE13] address latch and program store strobes high during reset
// [RULE14] watchdog overflow gives internal reset pulse of exactly 3 machine cycles
// [RULE15] enabled watchdog overflow resets device even with pin held low
// [RULE16] reset on second consecutive high sample, repeated until sampled low
// [RULE17] internal data RAM untouched by reset
// [RULE18] reset loads defined values: zeros, stack pointer 07h, ports ones
// [RULE19] reset writes ones into port pins once oscillator runs
// [RULE20] power-on reset pin high for oscillator start-up plus 2 cycles
// [RULE21] enabled interrupt during idle clears light sleep bit, ends idle
// [RULE22] power-down stops oscillator; only hardware reset ends it
// [RULE23] internal reset released in first machine cycle sampling pin low
`timescale 1ns/1ns
`include "pcr_map.svh"

module pcr_power_reset
    import pcr_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // special function register byte port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic       sfr_bit_op,
    input  wire logic [7:0] sfr_wdata,
    output logic [7:0]      sfr_rdata,
    output logic            sfr_hit,
    // reset pin and watchdog
    input  wire logic       reset_pin,
    input  wire logic       wdog_overflow,
    input  wire logic       wdog_enable,
    input  wire logic       wdog_load,
    output logic            wdog_load_allowed,
    output logic            wdog_reset_drive,
    // power control inputs
    input  wire logic       powerdown_permit_input,
    input  wire logic       irq_pending,
    input  wire logic       serial_mode_nonzero,
    // strobes from the core and to the pins
    input  wire logic       core_ale,
    input  wire logic       core_program_store_strobe,
    output logic            ale_pin,
    output logic            program_store_strobe,
    // status and control to the rest of the chip
    output logic            internal_reset,
    output logic            cpu_halted,
    output logic            osc_stopped,
    output logic            baud_double_active,
    // defined register loads driven on internal reset
    output logic [7:0]      reset_value_zero,
    output logic [7:0]      stack_pointer_reset,
    output logic [7:0]      ports_zero_to_four
);

    typedef struct packed
    {
        logic           baud_doubler;
        logic           reserved6;
        logic           quiet_strobe_bit;
        logic           watchdog_load_permit;
        logic           user_flag_b;
        logic           user_flag_a;
        logic           deep_sleep_request;
        logic           light_sleep_request;
        pcr_rst_state_t rst_state;
        logic [1:0]     wdog_cnt;
        logic           wdog_pend;
        logic           in_reset;
        logic           ale_out;
        logic           pse_out;
        logic [7:0]     rdata;
        logic           hit;
        logic [7:0]     ports;
    } pcr_state_t;

    pcr_state_t s_q;
    pcr_state_t s_d;

    logic           mcycle_stb;
    logic           pin_level;
    logic           osc_run;
    logic           sample_high;
    logic           reg_sel;
    logic           wr_sel;
    logic           rd_sel;
    logic           wdog_fire;
    logic           load_taken;
    logic           idle_wake;
    logic           pd_wake;
    logic [7:0]     reg_image;
    pcr_pwr_state_t pwr_mode;

    // no machine cycles while the oscillator is frozen in power-down
    assign osc_run = ~s_q.deep_sleep_request; // [RULE22]

    // machine-cycle strobe, frozen while the oscillator is stopped
    pcr_mcycle_div u_div
    (
        .clock      (clock),
        .rst        (rst),
        .run        (osc_run),
        .mcycle_stb (mcycle_stb)
    );

    // reset pin through the three-stage synchroniser
    pcr_pin_sync u_sync
    (
        .clock   (clock),
        .rst     (rst),
        .pin_in  (reset_pin),
        .pin_out (pin_level)
    );

    // bit operations never decode this address: byte access only
    assign reg_sel = (sfr_addr == `PCR_POWER_CONTROL_ADDR) & ~sfr_bit_op; // [RULE9]

    // the pin line is seen high when driven from outside or by the watchdog pulse
    assign sample_high = pin_level | (s_q.wdog_cnt != 2'h0); // [RULE15]

    // decoded accesses; writes are locked out while reset is applied
    assign wr_sel = reg_sel & sfr_wr & ~s_q.in_reset;
    assign rd_sel = reg_sel & sfr_rd;

    // read image; the reserved bit reads back as zero
    assign reg_image = {s_q.baud_doubler, 1'b0, s_q.quiet_strobe_bit,
                        s_q.watchdog_load_permit, s_q.user_flag_b, s_q.user_flag_a,
                        s_q.deep_sleep_request, s_q.light_sleep_request}; // [RULE10]

    // a new overflow is taken only when no pulse is pending or running
    assign wdog_fire = wdog_overflow & wdog_enable & (s_q.wdog_cnt == 2'h0)
                       & ~s_q.wdog_pend; // [RULE15]

    // a watchdog load consumes the permit that software set beforehand
    assign load_taken = wdog_load & s_q.watchdog_load_permit; // [RULE4]

    // wake events: interrupt ends idle, a high pin ends power-down
    assign idle_wake = irq_pending & s_q.light_sleep_request; // [RULE21]
    assign pd_wake   = s_q.deep_sleep_request & pin_level;    // [RULE22]

    always_comb
    begin
        s_d       = s_q;
        s_d.hit   = reg_sel & (sfr_rd | sfr_wr);
        s_d.rdata = `PCR_ZERO_RST;
        pwr_mode  = PCR_PWR_NORMAL;

        // byte-wide register access
        if (rd_sel)
        begin
            s_d.rdata = reg_image;
        end
        if (wr_sel)
        begin
            s_d.baud_doubler         = sfr_wdata[`PCR_BIT_BAUD_DOUBLER];   // [RULE1]
            s_d.quiet_strobe_bit     = sfr_wdata[`PCR_BIT_QUIET_STROBE];   // [RULE2]
            s_d.watchdog_load_permit = sfr_wdata[`PCR_BIT_WDOG_PERMIT];
            s_d.user_flag_b          = sfr_wdata[`PCR_BIT_USER_FLAG_B];    // [RULE5]
            s_d.user_flag_a          = sfr_wdata[`PCR_BIT_USER_FLAG_A];    // [RULE5]
            // deep sleep only sticks while the permit input is high
            s_d.deep_sleep_request   = sfr_wdata[`PCR_BIT_DEEP_SLEEP]
                                       & powerdown_permit_input;           // [RULE6]
            // with both set and the permit input high, power-down wins and idle is not entered
            s_d.light_sleep_request  = sfr_wdata[`PCR_BIT_LIGHT_SLEEP]
                                       & ~s_d.deep_sleep_request;          // [RULE7] [RULE8]
        end

        // a watchdog load consumes the permit; the load beats a same-cycle write
        if (load_taken)
        begin
            s_d.watchdog_load_permit = 1'b0; // [RULE4]
        end

        // an enabled interrupt ends idle
        if (idle_wake)
        begin
            s_d.light_sleep_request = 1'b0; // [RULE21]
        end

        // an overflow waits for the next machine-cycle edge, so the pulse
        // spans three whole machine cycles whatever the overflow's phase
        if (wdog_fire)
        begin
            s_d.wdog_pend = 1'b1; // [RULE15]
        end
        if (mcycle_stb & s_q.wdog_pend)
        begin
            s_d.wdog_pend = 1'b0;
            s_d.wdog_cnt  = `PCR_WDOG_PULSE_MCYCLES; // [RULE14] [RULE15]
        end
        else if (mcycle_stb & (s_q.wdog_cnt != 2'h0))
        begin
            s_d.wdog_cnt = s_q.wdog_cnt - 2'h1; // [RULE14]
        end

        // sample the reset line once per machine cycle
        if (mcycle_stb)
        begin
            case (s_q.rst_state) // [RULE11]
                PCR_RUN:
                begin
                    // a first high sample arms the sequencer
                    if (sample_high)
                    begin
                        s_d.rst_state = PCR_SEEN_ONE;
                    end
                end
                PCR_SEEN_ONE:
                begin
                    // second consecutive high sample executes the reset
                    if (sample_high)
                    begin
                        s_d.rst_state = PCR_IN_RESET; // [RULE16]
                    end
                    else
                    begin
                        s_d.rst_state = PCR_RUN;
                    end
                end
                PCR_IN_RESET:
                begin
                    // first low sample releases reset
                    if (!sample_high)
                    begin
                        s_d.rst_state = PCR_RUN; // [RULE23]
                    end
                end
                default:
                begin
                    s_d.rst_state = PCR_RUN;
                end
            endcase
        end

        // power-down has no machine cycles, so a high pin wakes it directly
        if (pd_wake)
        begin
            s_d.rst_state = PCR_IN_RESET; // [RULE22]
        end

        // reset level of the coming cycle
        s_d.in_reset = (s_d.rst_state == PCR_IN_RESET);

        // reset reloads register defaults every cycle it stays active
        if (s_d.in_reset)
        begin
            s_d.baud_doubler         = 1'b0; // [RULE10]
            s_d.quiet_strobe_bit     = 1'b0; // [RULE2]
            s_d.watchdog_load_permit = 1'b0;
            s_d.user_flag_b          = 1'b0;
            s_d.user_flag_a          = 1'b0;
            s_d.deep_sleep_request   = 1'b0;
            s_d.light_sleep_request  = 1'b0;
            s_d.ports                = `PCR_PORTS_RST; // [RULE18] [RULE19]
        end

        // power mode of the coming cycle; reset overrides both sleep modes
        if (s_d.in_reset)
        begin
            pwr_mode = PCR_PWR_NORMAL;
        end
        else if (s_d.deep_sleep_request)
        begin
            pwr_mode = PCR_PWR_DOWN; // [RULE8]
        end
        else if (s_d.light_sleep_request)
        begin
            pwr_mode = PCR_PWR_IDLE;
        end

        // strobes: idle parks both high, power-down drives both low
        case (pwr_mode)
            PCR_PWR_IDLE:
            begin
                s_d.ale_out = 1'b1;
                s_d.pse_out = 1'b1;
            end
            PCR_PWR_DOWN:
            begin
                s_d.ale_out = 1'b0;
                s_d.pse_out = 1'b0; // [RULE22]
            end
            default:
            begin
                // strobes high during reset; quiet strobe freezes the latch strobe high
                s_d.ale_out = s_d.in_reset | s_d.quiet_strobe_bit | core_ale; // [RULE13] [RULE2]
                s_d.pse_out = s_d.in_reset | core_program_store_strobe;       // [RULE13]
            end
        endcase
    end

    // ports power up undefined in silicon; here rst loads them with all ones
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_q           <= '0;
            s_q.rst_state <= PCR_IN_RESET;
            s_q.in_reset  <= 1'b1;
            s_q.ale_out   <= 1'b1;
            s_q.pse_out   <= 1'b1;
            s_q.ports     <= `PCR_PORTS_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // register port; no RAM is held here so reset cannot disturb it
    assign sfr_rdata           = s_q.rdata; // [RULE17]
    assign sfr_hit             = s_q.hit;

    // watchdog side
    assign wdog_load_allowed   = s_q.watchdog_load_permit;
    assign wdog_reset_drive    = (s_q.wdog_cnt != 2'h0);

    // strobe pins
    assign ale_pin             = s_q.ale_out;
    assign program_store_strobe = s_q.pse_out;

    // status to the core and the serial port
    assign internal_reset      = s_q.in_reset;
    assign cpu_halted          = s_q.light_sleep_request | s_q.deep_sleep_request;
    assign osc_stopped         = s_q.deep_sleep_request;
    assign baud_double_active  = s_q.baud_doubler & serial_mode_nonzero; // [RULE1]

    // values the core loads while internal reset stands
    assign reset_value_zero    = `PCR_ZERO_RST;                          // [RULE18]
    assign stack_pointer_reset = `PCR_STACK_POINTER_RST;                 // [RULE18]
    assign ports_zero_to_four  = s_q.ports;

endmodule

// file: src/pcr_map.svh
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

// special function register address of the power-control register
`define PCR_POWER_CONTROL_ADDR 8'h87

// power-control field positions
`define PCR_BIT_BAUD_DOUBLER   7
`define PCR_BIT_RESERVED       6
`define PCR_BIT_QUIET_STROBE   5
`define PCR_BIT_WDOG_PERMIT    4
`define PCR_BIT_USER_FLAG_B    3
`define PCR_BIT_USER_FLAG_A    2
`define PCR_BIT_DEEP_SLEEP     1
`define PCR_BIT_LIGHT_SLEEP    0

// reset values
`define PCR_POWER_CONTROL_RST  8'h00
`define PCR_STACK_POINTER_RST  8'h07
`define PCR_PORTS_RST          8'hff
`define PCR_ZERO_RST           8'h00

// timing: 12 oscillator periods form one machine cycle
`define PCR_OSC_PER_MCYCLE     4'hc
`define PCR_WDOG_PULSE_MCYCLES 2'h3
`define PCR_PIN_HIGH_MCYCLES   2'h2

`endif

// file: src/pcr_pkg.sv
package pcr_pkg;

    // reset sequencer states
    typedef enum logic [1:0]
    {
        PCR_RUN,
        PCR_SEEN_ONE,
        PCR_IN_RESET
    } pcr_rst_state_t;

    // power state of the core
    typedef enum logic [1:0]
    {
        PCR_PWR_NORMAL,
        PCR_PWR_IDLE,
        PCR_PWR_DOWN
    } pcr_pwr_state_t;

endpackage

// file: src/pcr_mcycle_div.sv
`timescale 1ns/1ns
`include "pcr_map.svh"

// divides the oscillator clock into one-cycle machine-cycle strobes
module pcr_mcycle_div
    import pcr_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // run control: stopped oscillator gives no machine cycles
    input  wire logic run,
    // strobe
    output logic      mcycle_stb
);

    typedef struct packed
    {
        logic [3:0] cnt;
        logic       stb;
    } pcr_div_state_t;

    pcr_div_state_t s_q;
    pcr_div_state_t s_d;

    // count twelve oscillator periods per machine cycle
    always_comb
    begin
        s_d     = s_q;
        s_d.stb = 1'b0;
        if (run)
        begin
            if (s_q.cnt == `PCR_OSC_PER_MCYCLE - 4'h1)
            begin
                s_d.cnt = 4'h0;
                s_d.stb = 1'b1;
            end
            else
            begin
                s_d.cnt = s_q.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign mcycle_stb = s_q.stb;

endmodule

// file: src/pcr_pin_sync.sv
`timescale 1ns/1ns

// three-stage synchroniser; a change counts once stages two and three agree
module pcr_pin_sync
    import pcr_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // asynchronous pin level and its filtered copy
    input  wire logic pin_in,
    output logic      pin_out
);

    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } pcr_sync_state_t;

    pcr_sync_state_t s_q;
    pcr_sync_state_t s_d;

    // first stage feeds only the second; level follows agreeing later stages
    always_comb
    begin
        s_d    = s_q;
        s_d.s1 = pin_in;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        if (s_q.s2 == s_q.s3)
        begin
            s_d.level = s_q.s3;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pin_out = s_q.level;

endmodule

// file: verification/pcr_power_reset_checker.sv
`timescale 1ns/1ns

// watches the power-control and reset block from its ports only
module pcr_power_reset_checker (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // register port
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_rd,
    input wire logic       sfr_bit_op,
    input wire logic [7:0] sfr_rdata,
    input wire logic       sfr_hit,
    // reset pin and watchdog
    input wire logic       reset_pin,
    input wire logic       wdog_reset_drive,
    // status and pins
    input wire logic       serial_mode_nonzero,
    input wire logic       ale_pin,
    input wire logic       program_store_strobe,
    input wire logic       internal_reset,
    input wire logic       osc_stopped,
    input wire logic       baud_double_active,
    input wire logic [7:0] reset_value_zero,
    input wire logic [7:0] stack_pointer_reset,
    input wire logic [7:0] ports_zero_to_four
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    logic [7:0] drv_cnt_q; // length of the running watchdog pulse
    logic [7:0] hi_cnt_q;  // cycles the pin has stood high
    logic [7:0] lo_cnt_q;  // cycles pin and pulse both stood low

    // counters wrap harmlessly: the level they watch still holds then
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            drv_cnt_q <= 8'h00;
            hi_cnt_q  <= 8'h00;
            lo_cnt_q  <= 8'h00;
        end
        else
        begin
            drv_cnt_q <= wdog_reset_drive ? drv_cnt_q + 8'h01 : 8'h00;
            hi_cnt_q  <= reset_pin ? hi_cnt_q + 8'h01 : 8'h00;
            lo_cnt_q  <= (reset_pin || wdog_reset_drive) ? 8'h00 : lo_cnt_q + 8'h01;
        end
    end

    // a matched byte read, and the reset due within 60 cycles of a watchdog pulse
    sequence s_read_req;
        sfr_rd && sfr_addr == 8'h87 && !sfr_bit_op;
    endsequence
    sequence s_wdog_reset;
        ##[1:60] internal_reset;
    endsequence

    a_read_answer: assert property (s_read_req |=> sfr_hit)
        else $error("register read not answered");
    a_refused_access: assert property ((sfr_rd && (sfr_bit_op || sfr_addr != 8'h87))
        |=> !sfr_hit && sfr_rdata == 8'h00)
        else $error("bit or foreign access answered");
    a_reserved_zero: assert property (sfr_hit |-> !sfr_rdata[6])
        else $error("reserved bit reads one");
    a_strobes_reset: assert property (internal_reset && $past(internal_reset)
        |-> ale_pin && program_store_strobe)
        else $error("strobe low during reset");
    a_ports_ones: assert property (internal_reset && $past(internal_reset)
        |-> ports_zero_to_four == 8'hff)
        else $error("ports not all ones in reset");
    a_const_loads: assert property (reset_value_zero == 8'h00
        && stack_pointer_reset == 8'h07)
        else $error("reset load constants wrong");
    a_baud_mode: assert property (!serial_mode_nonzero |-> !baud_double_active)
        else $error("baud doubled in mode zero");
    a_powerdown_pins: assert property (osc_stopped && $past(osc_stopped) && !internal_reset
        |-> !ale_pin && !program_store_strobe)
        else $error("strobes high in power-down");
    a_pin_reset: assert property (hi_cnt_q == 8'h28 |-> internal_reset)
        else $error("long pin high gave no reset");
    a_pin_release: assert property (lo_cnt_q == 8'h28 |-> !internal_reset)
        else $error("reset not released after pin low");
    a_wdog_width: assert property ($fell(wdog_reset_drive) |-> drv_cnt_q == 8'h24)
        else $error("watchdog pulse not three machine cycles");
    a_wdog_reset: assert property ($rose(wdog_reset_drive) |-> s_wdog_reset)
        else $error("watchdog pulse gave no reset");
endmodule

bind pcr_power_reset pcr_power_reset_checker u_pcr_power_reset_checker (.*);

// file: verification/pcr_reset_source.sv
`timescale 1ns/1ns

// external reset source: holds the pin high for a set number of clocks
module pcr_reset_source (
    // clock
    input  wire logic       clock,
    // pulse request from the bench
    input  wire logic       go,
    input  wire logic [7:0] len,
    // pin, low whenever the source is idle
    output logic            reset_pin
);
    // power-on hold covers start-up plus two machine cycles
    logic [7:0] cnt_q = 8'h30;

    // a length under 24 clocks breaks the hold time only when commanded
    always_ff @(posedge clock)
    begin
        if (go)
            cnt_q <= len;
        else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end

    assign reset_pin = (cnt_q != 8'h00);
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ns

module testbench;
    logic       clock, rst, sfr_wr, sfr_rd, sfr_bit_op, reset_pin;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, pin_len;
    logic       sfr_hit, wdog_overflow, wdog_enable, wdog_load, pin_go;
    logic       wdog_load_allowed, wdog_reset_drive, powerdown_permit_input;
    logic       irq_pending, serial_mode_nonzero, core_ale, core_program_store_strobe;
    logic       ale_pin, program_store_strobe, internal_reset, cpu_halted;
    logic       osc_stopped, baud_double_active;
    logic [7:0] reset_value_zero, stack_pointer_reset, ports_zero_to_four;
    int         fails, checks_done;

    pcr_power_reset u_pcr_power_reset (.*);
    pcr_reset_source u_pcr_reset_source (.clock(clock), .go(pin_go), .len(pin_len),
        .reset_pin(reset_pin));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // core strobes toggle every cycle so a frozen pin stands out
    always @(posedge clock)
    begin
        #1;
        core_ale = ~core_ale;
        core_program_store_strobe = ~core_program_store_strobe;
    end

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [7:0] d, input logic bo = 1'b0);
        sfr_addr = 8'h87;
        sfr_wdata = d;
        sfr_bit_op = bo;
        sfr_wr = 1'b1;
        cyc(1);
        sfr_wr = 1'b0;
        sfr_bit_op = 1'b0;
        cyc(1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        sfr_addr = a;
        sfr_rd = 1'b1;
        cyc(1);
        d = sfr_rdata;
        h = sfr_hit;
        sfr_rd = 1'b0;
        cyc(1);
    endtask

    task automatic rk(input logic [7:0] exp);
        logic [7:0] d;
        logic       h;
        rd(8'h87, d, h);
        chk("power_control", d, exp);
        chk("hit", 8'(h), 8'h01);
    endtask

    // bounded wait for the internal reset level
    task automatic wait_ir(input logic v);
        int n;
        n = 0;
        while (internal_reset !== v && n < 100)
        begin
            cyc(1);
            n++;
        end
        chk("internal_reset", 8'(internal_reset), 8'(v));
    endtask

    task automatic pin_pulse(input logic [7:0] n);
        pin_len = n;
        pin_go = 1'b1;
        cyc(1);
        pin_go = 1'b0;
    endtask

    task automatic t_regs();
        logic [7:0] d;
        logic       h;
        wr(8'h4c);
        rk(8'h0c);
        wr(8'h00, 1'b1);
        rk(8'h0c);
        rd(8'h86, d, h);
        chk("foreign hit", 8'(h), 8'h00);
        wr(8'h80);
        serial_mode_nonzero = 1'b1;
        cyc(1);
        chk("baud", 8'(baud_double_active), 8'h01);
        wr(8'h00);
        chk("baud off", 8'(baud_double_active), 8'h00);
        $display("t_regs done");
    endtask

    task automatic t_permit();
        wr(8'h10);
        chk("permit", 8'(wdog_load_allowed), 8'h01);
        wdog_load = 1'b1;
        cyc(1);
        wdog_load = 1'b0;
        cyc(1);
        chk("permit cleared", 8'(wdog_load_allowed), 8'h00);
        rk(8'h00);
        $display("t_permit done");
    endtask

    task automatic t_sleep();
        wr(8'h01);
        chk("idle halt", 8'(cpu_halted), 8'h01);
        chk("idle osc", 8'(osc_stopped), 8'h00);
        irq_pending = 1'b1;
        cyc(3);
        irq_pending = 1'b0;
        chk("idle end", 8'(cpu_halted), 8'h00);
        rk(8'h00);
        wr(8'h02);
        rk(8'h00);
        chk("no power-down", 8'(osc_stopped), 8'h00);
        powerdown_permit_input = 1'b1;
        wr(8'h03);
        chk("power-down", 8'(osc_stopped), 8'h01);
        irq_pending = 1'b1;
        cyc(30);
        irq_pending = 1'b0;
        chk("still down", 8'(osc_stopped), 8'h01);
        chk("down ale", 8'(ale_pin), 8'h00);
        chk("down pse", 8'(program_store_strobe), 8'h00);
        pin_pulse(8'h30);
        wait_ir(1'b1);
        wait_ir(1'b0);
        chk("osc running", 8'(osc_stopped), 8'h00);
        rk(8'h00);
        $display("t_sleep done");
    endtask

    task automatic t_pin();
        int n;
        logic v;
        n = 0;
        wr(8'h20);
        v = ale_pin;
        repeat (8)
        begin
            cyc(1);
            n += int'(ale_pin !== v);
        end
        chk("quiet ale", 8'(n), 8'h00);
        pin_pulse(8'h0a);
        n = 0;
        repeat (40)
        begin
            cyc(1);
            n += int'(internal_reset !== 1'b0);
        end
        chk("short pulse", 8'(n), 8'h00);
        rk(8'h20);
        pin_pulse(8'h50);
        wait_ir(1'b1);
        cyc(30);
        chk("held", 8'(internal_reset), 8'h01);
        wait_ir(1'b0);
        rk(8'h00);
        $display("t_pin done");
    endtask

    task automatic t_wdog();
        int n;
        logic hit;
        n = 0;
        hit = 1'b0;
        wdog_enable = 1'b1;
        wdog_overflow = 1'b1;
        cyc(1);
        wdog_overflow = 1'b0;
        while (wdog_reset_drive !== 1'b1 && n < 20)
        begin
            cyc(1);
            n++;
        end
        n = 0;
        while (wdog_reset_drive === 1'b1 && n < 100)
        begin
            cyc(1);
            n++;
            hit |= internal_reset;
        end
        chk("pulse length", 8'(n), 8'h24);
        chk("wdog reset", 8'(hit), 8'h01);
        wait_ir(1'b0);
        wdog_enable = 1'b0;
        $display("t_wdog done");
    endtask

    task automatic close_out();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // run limit well beyond the expected length of all tests
    initial
    begin
        #200000;
        fails++;
        close_out();
    end

    initial
    begin
        {rst, sfr_wr, sfr_rd, sfr_bit_op, wdog_overflow, wdog_enable} = 6'h20;
        {wdog_load, powerdown_permit_input, irq_pending, serial_mode_nonzero} = 4'h0;
        {core_ale, core_program_store_strobe, pin_go} = 3'h0;
        {sfr_addr, sfr_wdata, pin_len} = {8'h87, 8'h00, 8'h00};
        fails = 0;
        checks_done = 0;
        cyc(16);
        rst = 1'b0;
        chk("reset strobes", 8'({ale_pin, program_store_strobe}), 8'h03);
        chk("ports", ports_zero_to_four, 8'hff);
        chk("sp reset", stack_pointer_reset, 8'h07);
        chk("zero reset", reset_value_zero, 8'h00);
        wait_ir(1'b0);
        rk(8'h00);
        t_regs();
        t_permit();
        t_sleep();
        t_pin();
        t_wdog();
        close_out();
    end
endmodule
